// ---- logic/dee_row_programmer.sv ----
// Purpose: data EEPROM access controller with 32-byte row latches
// Assumes: all inputs come from logic on sys_clk; one bus access per cycle
// Notes:   read answers appear one cycle after the request

`timescale 1ns/100ps
`default_nettype none

module dee_row_programmer #(
    parameter int EE_ROWS      = dee_pkg::ARRAY_ROWS,
    parameter int PROG_CYCLES  = dee_pkg::PROG_CYCLES,
    parameter int ERASE_CYCLES = dee_pkg::ERASE_CYCLES
) (
    // clock and reset
    input  wire logic                                    sys_clk,
    input  wire logic                                    rst_b,
    // core bus
    input  wire logic [$clog2(EE_ROWS)+dee_pkg::COL_W-1:0] bus_addr,
    input  wire logic [7:0]                              bus_wdata,
    input  wire logic                                    bus_wr,
    input  wire logic                                    bus_rd,
    input  wire logic                                    ee_sel,
    input  wire logic                                    csr_sel,
    output logic      [7:0]                              bus_rdata,
    output logic                                         bus_rdata_oe,
    // external programming access
    input  wire logic [$clog2(EE_ROWS)+dee_pkg::COL_W-1:0] ext_addr,
    input  wire logic [7:0]                              ext_wdata,
    input  wire logic                                    ext_wr,
    input  wire logic                                    ext_rd,
    output logic      [7:0]                              ext_rdata,
    output logic                                         ext_rvalid,
    output logic                                         ext_blocked,
    // option and power control
    input  wire logic                                    readout_protect_option,
    input  wire logic                                    protect_clear_req,
    input  wire logic                                    wait_for_interrupt_instr,
    input  wire logic                                    halt_req,
    // status
    output logic                                         wait_ack,
    output logic                                         halted,
    output logic                                         prog_mem_erase,
    output logic                                         prog_done,
    output logic                                         write_latch_mode,
    output logic                                         program_start
);

    // ----------------------------------------------------------------
    // local sizes
    // ----------------------------------------------------------------
    localparam int ROW_W  = $clog2(EE_ROWS);
    localparam int ADDR_W = ROW_W + dee_pkg::COL_W;
    localparam int BYTES  = EE_ROWS * dee_pkg::ROW_BYTES;
    localparam int CNT_W  = $clog2((PROG_CYCLES > ERASE_CYCLES ? PROG_CYCLES : ERASE_CYCLES) + 1);

    typedef struct packed {
        dee_pkg::dee_state_t                      st;
        logic                                     lat;
        logic                                     program_bit;
        logic [ROW_W-1:0]                         row;
        logic [dee_pkg::ROW_BYTES-1:0]            lmask;
        logic [dee_pkg::ROW_BYTES-1:0][7:0]       ldata;
        logic [CNT_W-1:0]                         cnt;
        logic [7:0]                               rdata;
        logic                                     rdoe;
        logic [7:0]                               xdata;
        logic                                     xvalid;
        logic                                     xblock;
        logic                                     wait_ack;
        logic                                     halted;
        logic                                     erase_busy;
        logic                                     prog_done;
    } dee_regs_t;

    dee_regs_t r;
    dee_regs_t next_r;

    logic [7:0]                       mem [BYTES];
    logic                             mem_commit;
    logic                             mem_erase;
    logic                             wr_bus;
    logic                             wr_ext;
    logic [ADDR_W-1:0]                wr_addr;
    logic [7:0]                       wr_data;
    logic [dee_pkg::COL_W-1:0]        wr_col;
    logic                             prog_end;
    logic                             csr_wr;
    logic                             abort_req;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.rdoe = 1'b0;
        next_r.xvalid = 1'b0;
        next_r.xblock = 1'b0;
        next_r.prog_done = 1'b0;
        mem_commit = 1'b0;
        mem_erase = 1'b0;
        csr_wr = csr_sel && bus_wr;
        abort_req = csr_wr && !bus_wdata[dee_pkg::CSR_PGM_POS];
        prog_end = (r.st == dee_pkg::DEE_PROG) && (r.cnt == '0) && !abort_req;
        wr_bus = ee_sel && bus_wr && r.lat;
        wr_ext = !wr_bus && ext_wr && r.lat && !readout_protect_option;
        wr_addr = wr_bus ? bus_addr : ext_addr;
        wr_data = wr_bus ? bus_wdata : ext_wdata;
        wr_col = wr_addr[dee_pkg::COL_W-1:0];

        // latch capture, and-ing onto a byte already held
        if ((wr_bus || wr_ext) && r.st != dee_pkg::DEE_HALT) begin
            if (r.lmask[wr_col]) begin
                next_r.ldata[wr_col] = r.ldata[wr_col] & wr_data;
            end else begin
                next_r.ldata[wr_col] = wr_data;
            end
            next_r.lmask[wr_col] = 1'b1;
            next_r.row = wr_addr[ADDR_W-1:dee_pkg::COL_W];
        end

        unique case (r.st)
            dee_pkg::DEE_IDLE: begin
                if (csr_wr) begin
                    if (bus_wdata[dee_pkg::CSR_LAT_POS]) begin
                        next_r.lat = 1'b1;
                    end else if (!r.program_bit) begin
                        next_r.lat = 1'b0;
                    end
                    if (bus_wdata[dee_pkg::CSR_PGM_POS] && next_r.lat) begin
                        next_r.program_bit = 1'b1;
                        next_r.st = dee_pkg::DEE_PROG;
                        next_r.cnt = CNT_W'(PROG_CYCLES - 1);
                    end
                end else if (protect_clear_req) begin
                    next_r.st = dee_pkg::DEE_ERASE;
                    next_r.erase_busy = 1'b1;
                    next_r.cnt = CNT_W'(ERASE_CYCLES - 1);
                end
            end
            dee_pkg::DEE_PROG: begin
                next_r.cnt = r.cnt - 1'b1;
                if (abort_req) begin
                    next_r.program_bit = 1'b0;
                    next_r.st = dee_pkg::DEE_IDLE;
                end else if (prog_end) begin
                    mem_commit = 1'b1;
                    next_r.program_bit = 1'b0;
                    next_r.lat = 1'b0;
                    next_r.lmask = '0;
                    next_r.prog_done = 1'b1;
                    next_r.st = dee_pkg::DEE_IDLE;
                end
            end
            dee_pkg::DEE_ERASE: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == '0) begin
                    mem_erase = 1'b1;
                    next_r.erase_busy = 1'b0;
                    next_r.st = dee_pkg::DEE_IDLE;
                end
            end
            dee_pkg::DEE_HALT: begin
                if (!halt_req) begin
                    next_r.st = dee_pkg::DEE_IDLE;
                end
            end
        endcase

        // halt wins over every state change, program start, commit and erase
        if (halt_req) begin
            mem_commit = 1'b0;
            mem_erase = 1'b0;
            next_r.st = dee_pkg::DEE_HALT;
            next_r.program_bit = 1'b0;
            next_r.erase_busy = 1'b0;
        end
        next_r.halted = halt_req;

        // latch mode falling edge empties the latches
        if (r.lat && !next_r.lat) begin
            next_r.lmask = '0;
        end

        // wait entry once no cycle is running
        next_r.wait_ack = wait_for_interrupt_instr && (next_r.st == dee_pkg::DEE_IDLE);

        // core bus reads; latches never reach the bus
        next_r.rdata = 8'h00;
        if (csr_sel && bus_rd) begin
            next_r.rdoe = 1'b1;
            next_r.rdata = {dee_pkg::CSR_RSVD, r.lat, r.program_bit};
        end else if (ee_sel && bus_rd && !r.lat) begin
            next_r.rdoe = 1'b1;
            next_r.rdata = mem[bus_addr];
        end

        // external reads, blocked under protection
        if (ext_rd) begin
            next_r.xvalid = 1'b1;
            next_r.xblock = readout_protect_option;
            next_r.xdata = readout_protect_option ? dee_pkg::BLOCKED_BYTE : mem[ext_addr];
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // array cells
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < BYTES; i++) begin
            if (mem_erase) begin
                mem[i] <= dee_pkg::ERASED_BYTE;
            end else if (mem_commit && r.lmask[i % dee_pkg::ROW_BYTES]
                         && (i / dee_pkg::ROW_BYTES) == int'(r.row)) begin
                mem[i] <= r.ldata[i % dee_pkg::ROW_BYTES];
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus_rdata        = r.rdata;
    assign bus_rdata_oe     = r.rdoe;
    assign ext_rdata        = r.xdata;
    assign ext_rvalid       = r.xvalid;
    assign ext_blocked      = r.xblock;
    assign wait_ack         = r.wait_ack;
    assign halted           = r.halted;
    assign prog_mem_erase   = r.erase_busy;
    assign prog_done        = r.prog_done;
    assign write_latch_mode = r.lat;
    assign program_start    = r.program_bit;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [CNT_W:0] prog_len;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prog_len <= '0;
        end else if (r.st == dee_pkg::DEE_PROG) begin
            prog_len <= prog_len + 1'b1;
        end else begin
            prog_len <= '0;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence prog_begin;
        csr_wr && r.st == dee_pkg::DEE_IDLE && !halt_req
            && bus_wdata[dee_pkg::CSR_PGM_POS] && bus_wdata[dee_pkg::CSR_LAT_POS];
    endsequence

    sequence prog_finish;
        r.st == dee_pkg::DEE_PROG && r.cnt == '0 && !abort_req && !halt_req;
    endsequence

    AST_READ_ROM: assert property (ee_sel && bus_rd && !csr_sel && !r.lat |=> bus_rdata_oe)
        else $error("eeprom read in read mode not driven");
    AST_READ_FLOAT: assert property (ee_sel && bus_rd && !csr_sel && r.lat |=> !bus_rdata_oe)
        else $error("eeprom read in write mode drove the bus");
    AST_NO_CAPTURE: assert property (!r.lat |=> r.lmask == '0)
        else $error("latch captured while in read mode");
    AST_CAPTURE: assert property (ee_sel && bus_wr && r.lat && !halt_req && r.st == dee_pkg::DEE_IDLE
        |=> r.lmask[$past(bus_addr[dee_pkg::COL_W-1:0])])
        else $error("write in write mode not latched");
    AST_AND_MERGE: assert property (wr_bus && r.st == dee_pkg::DEE_IDLE && !halt_req && r.lmask[wr_col]
        |=> r.ldata[$past(wr_col)] == ($past(r.ldata[wr_col]) & $past(bus_wdata)))
        else $error("rewrite did not and old and new data");
    AST_START: assert property (prog_begin |=> r.program_bit && program_start ##0 r.st == dee_pkg::DEE_PROG)
        else $error("program start did not begin a cycle");
    AST_END_CLEARS: assert property (prog_finish |=> !r.program_bit && !r.lat && r.lmask == '0 && prog_done)
        else $error("cycle end did not clear both bits and latches");
    AST_DURATION: assert property (prog_done |-> prog_len == (CNT_W+1)'(PROG_CYCLES))
        else $error("programming cycle length wrong");
    AST_WAIT: assert property (wait_for_interrupt_instr && r.st == dee_pkg::DEE_IDLE && !csr_wr
        && !protect_clear_req && !halt_req |=> wait_ack)
        else $error("wait not entered while idle");
    AST_WAIT_BUSY: assert property (r.st == dee_pkg::DEE_PROG |-> !wait_ack || $past(r.st) != dee_pkg::DEE_PROG)
        else $error("wait entered during a running cycle");
    AST_HALT: assert property (halt_req |=> halted && !r.program_bit && r.st == dee_pkg::DEE_HALT)
        else $error("halt did not stop the controller");
    AST_KEEP_LAT: assert property (csr_wr && r.program_bit && !bus_wdata[dee_pkg::CSR_LAT_POS]
        && !halt_req && r.cnt != '0 |=> r.lat)
        else $error("latch mode cleared while programming");
    AST_ABORT: assert property (abort_req && r.st == dee_pkg::DEE_PROG && !halt_req
        |=> !r.program_bit && r.st == dee_pkg::DEE_IDLE && !prog_done)
        else $error("clearing program start did not abort");
    AST_CSR_RSVD: assert property (csr_sel && bus_rd |=> bus_rdata_oe && bus_rdata[7:2] == 6'h00)
        else $error("reserved control bits not zero");
    AST_PROTECT: assert property (ext_rd && readout_protect_option
        |=> ext_blocked && ext_rdata == dee_pkg::BLOCKED_BYTE)
        else $error("protected read leaked data");
    AST_ERASE: assert property (protect_clear_req && r.st == dee_pkg::DEE_IDLE && !csr_wr && !halt_req
        |=> prog_mem_erase [*2])
        else $error("protection removal did not start erase");
    AST_HALT_HOLD: assert property (r.st == dee_pkg::DEE_HALT |=> $stable(r.lmask))
        else $error("latches changed while halted");
    AST_PGM_IDLE: assert property (r.st != dee_pkg::DEE_PROG |-> !program_start)
        else $error("program start set outside a cycle");

endmodule

`default_nettype wire

// ---- logic/dee_pkg.sv ----
// Purpose: shared constants and types for the data EEPROM row programmer
// Assumes: core clock of 25 MHz, byte-wide core bus
// Notes:   cycle counts derive from the times below

package dee_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ       = 25;
    localparam int PROG_TIME_US  = 3;
    localparam int ERASE_TIME_US = 5;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int ROW_BYTES  = 32;
    localparam int COL_W      = 5;
    localparam int ARRAY_ROWS = 4;

    // ----------------------------------------------------------------
    // control/status register layout and values
    // ----------------------------------------------------------------
    localparam int         CSR_PGM_POS = 0;
    localparam int         CSR_LAT_POS = 1;
    localparam logic [5:0] CSR_RSVD    = 6'h00;
    localparam logic [7:0] CSR_RESET   = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] BLOCKED_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // controller states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DEE_IDLE,
        DEE_PROG,
        DEE_ERASE,
        DEE_HALT
    } dee_state_t;

endpackage

// ---- bench/dee_cpu_model.sv ----
// Purpose: core bus master model for the data EEPROM row programmer
// Assumes: byte accesses, strobes changed just after rising edges
// Notes:   released address and data lines carry inverted last values

`timescale 1ns/100ps
`default_nettype none

module dee_cpu_model #(
    parameter int AW = 7
) (
    // clock
    input  wire logic          sys_clk,
    // core bus
    output logic     [AW-1:0]  bus_addr,
    output logic     [7:0]     bus_wdata,
    output logic               bus_wr,
    output logic               bus_rd,
    output logic               ee_sel,
    output logic               csr_sel,
    input  wire logic [7:0]    bus_rdata,
    input  wire logic          bus_rdata_oe
);
    // data-only master, never fetches code from the array
    initial begin
        bus_addr  = '0;
        bus_wdata = 8'h00;
        {bus_wr, bus_rd, ee_sel, csr_sel} = 4'h0;
    end

    task automatic drive(input logic csr, input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        ee_sel    <= ~csr;
        csr_sel   <= csr;
    endtask

    task automatic free(input logic [AW-1:0] a, input logic [7:0] d);
        {bus_wr, bus_rd, ee_sel, csr_sel} <= 4'h0;
        bus_addr  <= ~a;
        bus_wdata <= ~d;
    endtask

    // one-cycle write, held through the taking edge
    task automatic wr(input logic csr, input logic [AW-1:0] a, input logic [7:0] d);
        drive(csr, a, d);
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        free(a, d);
    endtask

    // one-cycle read, answer sampled in the following cycle
    task automatic rd(input logic csr, input logic [AW-1:0] a,
                      output logic [7:0] d, output logic oe);
        drive(csr, a, 8'h00);
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        free(a, 8'h00);
        #1;
        d  = bus_rdata;
        oe = bus_rdata_oe;
    endtask
endmodule

`default_nettype wire

// ---- bench/dee_row_programmer_tb.sv ----
// Purpose: self-checking bench for the data EEPROM row programmer
// Assumes: short program and erase counts
// Notes:   scenarios run in sequence from one initial block

`timescale 1ns/100ps
`default_nettype none

module dee_row_programmer_tb;
    localparam int AW   = 7;
    localparam int PROG = 8;
    logic          sys_clk = 1'b0;
    logic          rst_b = 1'b0;
    logic [AW-1:0] bus_addr, ext_addr = '0;
    logic [7:0]    bus_wdata, bus_rdata, ext_rdata, ext_wdata = 8'h00;
    logic          bus_wr, bus_rd, ee_sel, csr_sel, bus_rdata_oe;
    logic          ext_wr = 1'b0, ext_rd = 1'b0, ext_rvalid, ext_blocked;
    logic          readout_protect_option = 1'b0, protect_clear_req = 1'b0;
    logic          wait_for_interrupt_instr = 1'b0, halt_req = 1'b0;
    logic          wait_ack, halted, prog_mem_erase, prog_done, write_latch_mode, program_start;
    int            error_cnt = 0;
    int            checks = 0;

    always #20 sys_clk = ~sys_clk;

    dee_row_programmer #(.EE_ROWS(4), .PROG_CYCLES(PROG), .ERASE_CYCLES(4)) uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .ee_sel(ee_sel), .csr_sel(csr_sel),
        .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
        .ext_rvalid(ext_rvalid), .ext_blocked(ext_blocked),
        .readout_protect_option(readout_protect_option), .protect_clear_req(protect_clear_req),
        .wait_for_interrupt_instr(wait_for_interrupt_instr), .halt_req(halt_req),
        .wait_ack(wait_ack), .halted(halted), .prog_mem_erase(prog_mem_erase),
        .prog_done(prog_done), .write_latch_mode(write_latch_mode),
        .program_start(program_start));

    dee_cpu_model #(.AW(AW)) cpu (
        .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .ee_sel(ee_sel), .csr_sel(csr_sel), .bus_rdata(bus_rdata),
        .bus_rdata_oe(bus_rdata_oe));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic give_up(input string msg);
        error_cnt++;
        $display("[FAIL] %0t timeout: %s", $time, msg);
        stop_test();
    endtask

    task automatic csr_wr(input logic [7:0] d);
        cpu.wr(1'b1, '0, d);
        #1;
    endtask

    task automatic ee_rd(input logic csr, input logic [AW-1:0] a, input logic oe_x,
                         input logic [7:0] x);
        logic [7:0] d;
        logic       oe;
        cpu.rd(csr, a, d, oe);
        chk({7'h00, oe}, {7'h00, oe_x}, "read drive");
        if (oe_x) chk(d, x, "read data");
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (prog_done !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 60) give_up("programming end");
        end
    endtask

    task automatic ext_read(input logic [AW-1:0] a, input logic blk, input logic [7:0] x);
        @(posedge sys_clk);
        ext_addr <= a;
        ext_rd   <= 1'b1;
        @(posedge sys_clk);
        ext_rd   <= 1'b0;
        #1;
        chk({6'h00, ext_rvalid, ext_blocked}, {7'h01, blk}, "ext answer");
        chk(ext_rdata, x, "ext data");
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk({6'h00, write_latch_mode, program_start}, 8'h00, "reset bits");
        csr_wr(8'hfc);
        ee_rd(1'b1, '0, 1'b1, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_erase();
        int n;
        @(posedge sys_clk);
        protect_clear_req <= 1'b1;
        @(posedge sys_clk);
        protect_clear_req <= 1'b0;
        #1;
        chk({7'h00, prog_mem_erase}, 8'h01, "erase start");
        for (n = 0; prog_mem_erase === 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
            if (n > 40) give_up("erase end");
        end
        for (n = 0; n < 4; n++) ee_rd(1'b0, AW'(n * 33), 1'b1, 8'hff);
        $display("test erase done");
    endtask

    task automatic t_row();
        int n;
        csr_wr(8'h02);
        chk({7'h00, write_latch_mode}, 8'h01, "enter write mode");
        cpu.wr(1'b0, 7'h25, 8'hf0);
        cpu.wr(1'b0, 7'h25, 8'h3c);
        cpu.wr(1'b0, 7'h21, 8'h55);
        csr_wr(8'h03);
        chk({7'h00, program_start}, 8'h01, "busy bit");
        wait_done(n);
        chk(8'(n), 8'(PROG), "cycle length");
        chk({6'h00, write_latch_mode, program_start}, 8'h00, "end clears");
        ee_rd(1'b0, 7'h25, 1'b1, 8'h30);
        ee_rd(1'b0, 7'h21, 1'b1, 8'h55);
        ee_rd(1'b0, 7'h22, 1'b1, 8'hff);
        csr_wr(8'h02);
        cpu.wr(1'b0, 7'h43, 8'h11);
        cpu.wr(1'b0, 7'h47, 8'h22);
        csr_wr(8'h03);
        wait_done(n);
        ee_rd(1'b0, 7'h43, 1'b1, 8'h11);
        ee_rd(1'b0, 7'h03, 1'b1, 8'hff);
        $display("test row done");
    endtask

    task automatic t_modes();
        int n;
        cpu.wr(1'b0, 7'h10, 8'h00);
        csr_wr(8'h02);
        ee_rd(1'b1, '0, 1'b1, 8'h02);
        ee_rd(1'b0, 7'h11, 1'b0, 8'h00);
        cpu.wr(1'b0, 7'h11, 8'haa);
        ee_rd(1'b0, 7'h11, 1'b0, 8'h00);
        csr_wr(8'h03);
        wait_done(n);
        ee_rd(1'b0, 7'h10, 1'b1, 8'hff);
        ee_rd(1'b0, 7'h11, 1'b1, 8'haa);
        $display("test modes done");
    endtask

    task automatic t_clear();
        int n;
        csr_wr(8'h02);
        cpu.wr(1'b0, 7'h08, 8'h0f);
        csr_wr(8'h00);
        csr_wr(8'h02);
        cpu.wr(1'b0, 7'h09, 8'hf0);
        csr_wr(8'h03);
        wait_done(n);
        ee_rd(1'b0, 7'h08, 1'b1, 8'hff);
        ee_rd(1'b0, 7'h09, 1'b1, 8'hf0);
        $display("test latch clear done");
    endtask

    task automatic t_abort();
        csr_wr(8'h02);
        cpu.wr(1'b0, 7'h0c, 8'h00);
        csr_wr(8'h03);
        csr_wr(8'h01);
        chk({6'h00, write_latch_mode, program_start}, 8'h03, "lat kept");
        csr_wr(8'h02);
        chk({6'h00, write_latch_mode, program_start}, 8'h02, "abort");
        repeat (PROG) @(posedge sys_clk);
        #1;
        chk({7'h00, write_latch_mode}, 8'h01, "no late end");
        csr_wr(8'h00);
        chk({7'h00, write_latch_mode}, 8'h00, "exit write mode");
        $display("test abort done");
    endtask

    task automatic t_wait();
        int n;
        @(posedge sys_clk);
        wait_for_interrupt_instr <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({7'h00, wait_ack}, 8'h01, "idle wait");
        @(posedge sys_clk);
        wait_for_interrupt_instr <= 1'b0;
        csr_wr(8'h02);
        cpu.wr(1'b0, 7'h00, 8'h5a);
        csr_wr(8'h03);
        @(posedge sys_clk);
        wait_for_interrupt_instr <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({7'h00, wait_ack}, 8'h00, "busy wait");
        wait_done(n);
        @(posedge sys_clk);
        #1;
        chk({7'h00, wait_ack}, 8'h01, "wait after end");
        @(posedge sys_clk);
        wait_for_interrupt_instr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        ee_rd(1'b0, 7'h00, 1'b1, 8'h5a);
        $display("test wait done");
    endtask

    task automatic t_halt();
        csr_wr(8'h02);
        cpu.wr(1'b0, 7'h01, 8'h00);
        csr_wr(8'h03);
        @(posedge sys_clk);
        halt_req <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({5'h00, halted, write_latch_mode, program_start}, 8'h06, "halt");
        @(posedge sys_clk);
        halt_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, halted}, 8'h00, "halt left");
        csr_wr(8'h00);
        $display("test halt done");
    endtask

    task automatic t_rst_mid();
        csr_wr(8'h02);
        csr_wr(8'h03);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({6'h00, write_latch_mode, program_start}, 8'h00, "reset in cycle");
        chk({7'h00, bus_rdata_oe}, 8'h00, "reset bus");
        $display("test mid reset done");
    endtask

    task automatic t_protect();
        int n;
        csr_wr(8'h02);
        @(posedge sys_clk);
        readout_protect_option <= 1'b1;
        ext_addr  <= 7'h21;
        ext_wdata <= 8'h00;
        ext_wr    <= 1'b1;
        @(posedge sys_clk);
        ext_wr    <= 1'b0;
        csr_wr(8'h03);
        wait_done(n);
        ext_read(7'h21, 1'b1, 8'h00);
        @(posedge sys_clk);
        readout_protect_option <= 1'b0;
        ext_read(7'h21, 1'b0, 8'h55);
        $display("test protect done");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_erase();
        t_row();
        t_modes();
        t_clear();
        t_abort();
        t_wait();
        t_halt();
        t_rst_mid();
        t_protect();
        stop_test();
    end
endmodule

`default_nettype wire
